// *** ftc_pkg.sv ***
package ftc_pkg;

	// ****************************************
	// Register indices (byte address = 4 * index)
	// ****************************************
	localparam logic [6:0] IDX_SMOOTH_CFG    = 7'h10;
	localparam logic [6:0] IDX_FIRST_CFG     = 7'h40;
	localparam logic [6:0] IDX_INT_STATUS    = 7'h41;
	localparam logic [6:0] IDX_SECOND_CFG    = 7'h73;
	localparam logic [6:0] IDX_INT_MASK1     = 7'h74;
	localparam logic [6:0] IDX_INT_MASK2     = 7'h75;
	localparam logic [6:0] IDX_VOLT_XRES     = 7'h76;
	localparam logic [6:0] IDX_TEMP_XRES     = 7'h77;
	localparam logic [6:0] IDX_THIRD_CFG     = 7'h78;
	localparam logic [6:0] IDX_TIMER_STATUS  = 7'h79;
	localparam logic [6:0] IDX_TIMER_LIMIT   = 7'h7a;
	localparam logic [6:0] IDX_TACH_PULSES   = 7'h7b;
	localparam logic [6:0] IDX_FIFTH_CFG     = 7'h7c;
	localparam logic [6:0] IDX_FOURTH_CFG    = 7'h7d;
	localparam logic [6:0] IDX_TEST_FIRST    = 7'h7e;
	localparam logic [6:0] IDX_TEST_SECOND   = 7'h7f;

	// ****************************************
	// Values after reset
	// ****************************************
	localparam logic [7:0] RST_ZERO          = 8'h00;
	localparam logic [7:0] RST_FIRST_CFG     = 8'h04;
	localparam logic [7:0] RST_TACH_PULSES   = 8'h55;
	localparam logic [7:0] RST_FIFTH_CFG     = 8'h01;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int SLOW_REMOTE1_BIT   = 0;
	localparam int SLOW_LOCAL_BIT     = 1;
	localparam int SLOW_REMOTE2_BIT   = 2;
	localparam int PROTECT_MANUAL_BIT = 3;
	localparam int CORE_LOW_BIT       = 6;
	localparam int EXTRA_STRETCH_BIT  = 7;
	localparam logic [7:0] SMOOTH_CFG_WMASK = 8'hcf;
	localparam int GO_BIT             = 0;
	localparam int LOCK_BIT           = 1;
	localparam int STAT_CORE_LOW_BIT  = 1;
	localparam int ALERT_EN_BIT       = 0;

	// ****************************************
	// Smoothing stretch figures
	// ****************************************
	localparam logic [1:0]  SLOW_DIV_LAST  = 2'h3;
	localparam logic [10:0] STRETCH_STEP   = 11'h3e8;
	localparam logic [10:0] STRETCH_PERIOD = 11'h570;

	// ****************************************
	// Spin-up timing
	// ****************************************
	localparam int CLK_HZ          = 100000000;
	localparam int SPIN_TIME_MS    = 250;
	localparam int SPIN_CYCLES     = SPIN_TIME_MS * (CLK_HZ / 1000);
	localparam logic [7:0] FULL_DUTY = 8'hff;

	typedef enum logic [1:0] {
		FTC_RUN  = 2'b00,
		FTC_LOW  = 2'b01,
		FTC_SPIN = 2'b11
	} ftc_core_state_t;

endpackage

// *** ftc_smooth_if.sv ***
`timescale 1ns/1ps
interface ftc_smooth_if;
	logic [2:0] tick;     // Base smoothing ticks per channel
	logic [2:0] slow;     // Four-times slow-down per channel
	logic       extra;    // Global extra stretch
	logic [2:0] step;     // Stretched smoothing steps
	modport ctrl (output tick, output slow, output extra, input step);
	modport timer (input tick, input slow, input extra, output step);
endinterface

// *** ftc_smooth_timer.sv ***
`timescale 1ns/1ps
module ftc_smooth_timer (
	input  wire logic    clk_i,   // System clock
	input  wire logic    rst_i,   // Synchronous reset
	ftc_smooth_if.timer  sm       // Smoothing tick channel group
);

	logic [1:0]  div_r [3];
	logic [10:0] acc_r [3];
	logic [11:0] sum   [3];
	logic [2:0]  wrap;
	logic [2:0]  step_r;
	logic [2:0]  mid;

	// ****************************************
	// Per-channel stretch
	// ****************************************
	// Divide by four first, then thin by 1000/1392 so period grows 39.2%
	always_ff @(posedge clk_i)
	begin
		for (int c = 0; c < 3; c++)
		begin
			if (rst_i)
			begin
				div_r[c] <= 2'h0;
				acc_r[c] <= 11'h000;
				step_r[c] <= 1'b0;
			end
			else
			begin
				if (sm.tick[c] && sm.slow[c])
					div_r[c] <= div_r[c] + 2'h1;
				if (mid[c] && sm.extra)
				begin
					if (wrap[c])
						acc_r[c] <= sum[c][10:0] - ftc_pkg::STRETCH_PERIOD;
					else
						acc_r[c] <= sum[c][10:0];
				end
				step_r[c] <= mid[c] && (!sm.extra || wrap[c]);
			end
		end
	end

	// Tick surviving the four-times divider; sum kept twelve bits wide
	// because accumulator plus step can exceed eleven bits
	always_comb
	begin
		for (int c = 0; c < 3; c++)
		begin
			mid[c]  = sm.tick[c] && (!sm.slow[c] || div_r[c] == ftc_pkg::SLOW_DIV_LAST);
			sum[c]  = {1'b0, acc_r[c]} + {1'b0, ftc_pkg::STRETCH_STEP};
			wrap[c] = sum[c] >= {1'b0, ftc_pkg::STRETCH_PERIOD};
		end
	end

	assign sm.step = step_r;

endmodule

// *** ftc_config_regs.sv ***
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
// Functional notes
// - Remote-one slow bit quarters fan one smoothing
// - Local slow bit quarters fan two smoothing
// - Remote-two slow bit quarters fan three smoothing
// - Manual-mode bit keeps thermal protection active
// - Thermal event overrides every fan setting except unprotected manual mode
// - Core voltage low: flag, alert, stop hot-monitor
// - Voltage recovers: monitor on, spin-up, resume
// - Extra-stretch bit lengthens smoothing by 39.2%
// - Lock bit makes lockable registers read-only
module ftc_config_regs #(
	parameter int SPIN_CYCLES = ftc_pkg::SPIN_CYCLES
) (
	input  wire logic        clk_i,              // System clock, 100 MHz
	input  wire logic        rst_i,              // Synchronous reset, high
	input  wire logic        cyc_i,              // Wishbone cycle
	input  wire logic        stb_i,              // Wishbone strobe
	input  wire logic        we_i,               // Wishbone write enable
	input  wire logic [8:0]  adr_i,              // Wishbone byte address
	input  wire logic [3:0]  sel_i,              // Wishbone byte selects
	input  wire logic [31:0] dat_i,              // Wishbone write data
	output logic      [31:0] dat_o,              // Wishbone read data
	output logic             ack_o,              // Wishbone acknowledge
	input  wire logic [2:0]  smooth_tick_i,      // Base smoothing ticks
	output logic      [2:0]  smooth_step_o,      // Stretched smoothing steps
	input  wire logic        thermal_overtemp_i, // Thermal event level
	input  wire logic        manual_mode_i,      // Fans under manual control
	input  wire logic [23:0] fan_duty_i,         // Programmed duty, 3 fans
	output logic      [23:0] fan_duty_o,         // Duty driven to fans
	input  wire logic        core_voltage_low_i, // Core voltage under limit
	output logic             hot_monitor_en_o,   // Processor hot monitor on
	output logic             monitoring_go_o,    // Monitoring enabled
	output logic             alert_o,            // Bus alert, level
	output logic             irq_o               // Interrupt, level
);

	// ****************************************
	// Bus decode
	// ****************************************
	logic [7:0]  smooth_cfg_r;
	logic [7:0]  first_cfg_r;
	logic [7:0]  int_status_r;
	logic [7:0]  second_cfg_r;
	logic [7:0]  int_mask1_r;
	logic [7:0]  int_mask2_r;
	logic [7:0]  volt_xres_r;
	logic [7:0]  temp_xres_r;
	logic [7:0]  third_cfg_r;
	logic [7:0]  timer_status_r;
	logic [7:0]  timer_limit_r;
	logic [7:0]  tach_pulses_r;
	logic [7:0]  fifth_cfg_r;
	logic [7:0]  fourth_cfg_r;
	logic        ack_r;
	logic [31:0] dat_r;
	logic        irq_r;
	logic        alert_r;
	logic [23:0] duty_r;
	logic        hot_en_r;
	logic        core_evt_r;

	wire  [6:0]  reg_idx;
	wire         bus_req;
	wire         wr_go;
	wire  [7:0]  wr_byte;
	wire         locked;

	// Index is the word address; only byte lane zero carries data
	assign reg_idx = adr_i[8:2];
	assign bus_req = cyc_i && stb_i && !ack_r;
	assign wr_go   = bus_req && we_i && sel_i[0];
	assign wr_byte = dat_i[7:0];
	assign locked  = first_cfg_r[ftc_pkg::LOCK_BIT];

	// Write strobe for one register index
	function automatic logic wr_hit(input logic [6:0] idx, input logic [6:0] target,
		input logic go);
		wr_hit = go && (idx == target);
	endfunction

	// Lockable write: refused once locked
	function automatic logic wr_hit_lk(input logic [6:0] idx, input logic [6:0] target,
		input logic go, input logic lk);
		wr_hit_lk = go && (idx == target) && !lk;
	endfunction

	wire wr_smooth  = wr_hit_lk(reg_idx, ftc_pkg::IDX_SMOOTH_CFG, wr_go, locked);
	wire wr_first   = wr_hit(reg_idx, ftc_pkg::IDX_FIRST_CFG, wr_go);
	wire wr_status  = wr_hit(reg_idx, ftc_pkg::IDX_INT_STATUS, wr_go);
	wire wr_second  = wr_hit_lk(reg_idx, ftc_pkg::IDX_SECOND_CFG, wr_go, locked);
	wire wr_mask1   = wr_hit(reg_idx, ftc_pkg::IDX_INT_MASK1, wr_go);
	wire wr_mask2   = wr_hit(reg_idx, ftc_pkg::IDX_INT_MASK2, wr_go);
	wire wr_vxres   = wr_hit(reg_idx, ftc_pkg::IDX_VOLT_XRES, wr_go);
	wire wr_txres   = wr_hit(reg_idx, ftc_pkg::IDX_TEMP_XRES, wr_go);
	wire wr_third   = wr_hit_lk(reg_idx, ftc_pkg::IDX_THIRD_CFG, wr_go, locked);
	wire wr_limit   = wr_hit(reg_idx, ftc_pkg::IDX_TIMER_LIMIT, wr_go);
	wire wr_pulses  = wr_hit(reg_idx, ftc_pkg::IDX_TACH_PULSES, wr_go);
	wire wr_fifth   = wr_hit_lk(reg_idx, ftc_pkg::IDX_FIFTH_CFG, wr_go, locked);
	wire wr_fourth  = wr_hit_lk(reg_idx, ftc_pkg::IDX_FOURTH_CFG, wr_go, locked);

	// ****************************************
	// Read selection
	// ****************************************
	// Unmapped and test indices read zero; bus still acknowledges
	wire [7:0] rd_byte =
		(reg_idx == ftc_pkg::IDX_SMOOTH_CFG)   ? smooth_cfg_r   :
		(reg_idx == ftc_pkg::IDX_FIRST_CFG)    ? first_cfg_r    :
		(reg_idx == ftc_pkg::IDX_INT_STATUS)   ? int_status_r   :
		(reg_idx == ftc_pkg::IDX_SECOND_CFG)   ? second_cfg_r   :
		(reg_idx == ftc_pkg::IDX_INT_MASK1)    ? int_mask1_r    :
		(reg_idx == ftc_pkg::IDX_INT_MASK2)    ? int_mask2_r    :
		(reg_idx == ftc_pkg::IDX_VOLT_XRES)    ? volt_xres_r    :
		(reg_idx == ftc_pkg::IDX_TEMP_XRES)    ? temp_xres_r    :
		(reg_idx == ftc_pkg::IDX_THIRD_CFG)    ? third_cfg_r    :
		(reg_idx == ftc_pkg::IDX_TIMER_STATUS) ? timer_status_r :
		(reg_idx == ftc_pkg::IDX_TIMER_LIMIT)  ? timer_limit_r  :
		(reg_idx == ftc_pkg::IDX_TACH_PULSES)  ? tach_pulses_r  :
		(reg_idx == ftc_pkg::IDX_FIFTH_CFG)    ? fifth_cfg_r    :
		(reg_idx == ftc_pkg::IDX_FOURTH_CFG)   ? fourth_cfg_r   :
		ftc_pkg::RST_ZERO;

	// One wait state: ack one cycle after the strobe, dropped the next
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
		end
		else
		begin
			ack_r <= bus_req;
			if (bus_req && !we_i)
				dat_r <= {24'h00_0000, rd_byte};
		end
	end

	// ****************************************
	// Configuration storage
	// ****************************************
	// Reserved bits five and four are never stored
	wire [7:0] smooth_wdata = wr_byte & ftc_pkg::SMOOTH_CFG_WMASK;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			smooth_cfg_r  <= ftc_pkg::RST_ZERO;
			second_cfg_r  <= ftc_pkg::RST_ZERO;
			int_mask1_r   <= ftc_pkg::RST_ZERO;
			int_mask2_r   <= ftc_pkg::RST_ZERO;
			volt_xres_r   <= ftc_pkg::RST_ZERO;
			temp_xres_r   <= ftc_pkg::RST_ZERO;
			third_cfg_r   <= ftc_pkg::RST_ZERO;
			timer_limit_r <= ftc_pkg::RST_ZERO;
			tach_pulses_r <= ftc_pkg::RST_TACH_PULSES;
			fifth_cfg_r   <= ftc_pkg::RST_FIFTH_CFG;
			fourth_cfg_r  <= ftc_pkg::RST_ZERO;
		end
		else
		begin
			if (wr_smooth)
				smooth_cfg_r <= smooth_wdata;
			if (wr_second)
				second_cfg_r <= wr_byte;
			if (wr_mask1)
				int_mask1_r <= wr_byte;
			if (wr_mask2)
				int_mask2_r <= wr_byte;
			if (wr_vxres)
				volt_xres_r <= wr_byte;
			if (wr_txres)
				temp_xres_r <= wr_byte;
			if (wr_third)
				third_cfg_r <= wr_byte;
			if (wr_limit)
				timer_limit_r <= wr_byte;
			if (wr_pulses)
				tach_pulses_r <= wr_byte;
			if (wr_fifth)
				fifth_cfg_r <= wr_byte;
			if (wr_fourth)
				fourth_cfg_r <= wr_byte;
		end
	end

	// Lock bit is sticky until reset; go bit stays writable when locked
	wire [7:0] first_nxt = {wr_byte[7:2],
		first_cfg_r[ftc_pkg::LOCK_BIT] | wr_byte[ftc_pkg::LOCK_BIT],
		wr_byte[ftc_pkg::GO_BIT]};

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			first_cfg_r <= ftc_pkg::RST_FIRST_CFG;
		else if (wr_first)
			first_cfg_r <= first_nxt;
	end

	// ****************************************
	// Core voltage low handling
	// ****************************************
	ftc_pkg::ftc_core_state_t core_st_r;
	ftc_pkg::ftc_core_state_t core_st_nxt;
	logic [31:0]              spin_cnt_r;

	wire core_watch = smooth_cfg_r[ftc_pkg::CORE_LOW_BIT];
	wire spin_done  = (spin_cnt_r == 32'(SPIN_CYCLES - 1));

	// Handling only armed while the standby bit is set
	always_comb
	begin
		core_st_nxt = core_st_r;
		case (core_st_r)
			ftc_pkg::FTC_RUN:
				if (core_watch && core_voltage_low_i)
					core_st_nxt = ftc_pkg::FTC_LOW;
			ftc_pkg::FTC_LOW:
				if (!core_voltage_low_i)
					core_st_nxt = ftc_pkg::FTC_SPIN;
			ftc_pkg::FTC_SPIN:
				if (spin_done)
					core_st_nxt = ftc_pkg::FTC_RUN;
			default:
				core_st_nxt = ftc_pkg::FTC_RUN;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			core_st_r  <= ftc_pkg::FTC_RUN;
			spin_cnt_r <= 32'h0000_0000;
		end
		else
		begin
			core_st_r <= core_st_nxt;
			if (core_st_r == ftc_pkg::FTC_SPIN && !spin_done)
				spin_cnt_r <= spin_cnt_r + 32'h0000_0001;
			else
				spin_cnt_r <= 32'h0000_0000;
		end
	end

	// Entry into the low state is the status event
	wire core_low_evt = (core_st_r == ftc_pkg::FTC_RUN) &&
		(core_st_nxt == ftc_pkg::FTC_LOW);

	// ****************************************
	// Interrupt status and outputs
	// ****************************************
	// Set wins over a write-one clear in the same cycle
	wire [7:0] status_set = {6'h00, core_low_evt, 1'b0} << 0;
	wire [7:0] status_clr = wr_status ? wr_byte : 8'h00;
	wire [7:0] status_nxt = (int_status_r & ~status_clr) | status_set;
	// Mask bit high hides the event
	wire       pending    = |(status_nxt & ~int_mask1_r);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			int_status_r <= ftc_pkg::RST_ZERO;
			irq_r        <= 1'b0;
			alert_r      <= 1'b0;
		end
		else
		begin
			int_status_r <= status_nxt;
			irq_r        <= pending;
			alert_r      <= pending && third_cfg_r[ftc_pkg::ALERT_EN_BIT];
		end
	end

	// ****************************************
	// Fan override path
	// ****************************************
	// Protection in manual mode only when asked; programmed duty ignored
	wire thermal_force = thermal_overtemp_i &&
		(!manual_mode_i || smooth_cfg_r[ftc_pkg::PROTECT_MANUAL_BIT]);
	wire spin_force    = (core_st_r == ftc_pkg::FTC_SPIN);
	wire hot_en_nxt    = (core_st_r != ftc_pkg::FTC_LOW);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			duty_r         <= 24'h00_0000;
			hot_en_r       <= 1'b1;
			timer_status_r <= ftc_pkg::RST_ZERO;
		end
		else
		begin
			// Override beats disabled fans too, hence no enable term
			duty_r   <= (thermal_force || spin_force) ?
				{3{ftc_pkg::FULL_DUTY}} : fan_duty_i;
			hot_en_r <= hot_en_nxt;
			timer_status_r <= {7'h00, thermal_overtemp_i};
		end
	end

	// ****************************************
	// Smoothing stretch
	// ****************************************
	ftc_smooth_if smooth_bus ();

	assign smooth_bus.tick     = smooth_tick_i;
	// One driver for the whole slow vector
	assign smooth_bus.slow     = {
		smooth_cfg_r[ftc_pkg::SLOW_REMOTE2_BIT],
		smooth_cfg_r[ftc_pkg::SLOW_LOCAL_BIT],
		smooth_cfg_r[ftc_pkg::SLOW_REMOTE1_BIT]
	};
	assign smooth_bus.extra    = smooth_cfg_r[ftc_pkg::EXTRA_STRETCH_BIT];

	ftc_smooth_timer u_smooth (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.sm    (smooth_bus.timer)
	);

	// ****************************************
	// Port drive
	// ****************************************
	assign dat_o            = dat_r;
	assign ack_o            = ack_r;
	assign irq_o            = irq_r;
	assign alert_o          = alert_r;
	assign fan_duty_o       = duty_r;
	assign hot_monitor_en_o = hot_en_r;
	assign monitoring_go_o  = first_cfg_r[ftc_pkg::GO_BIT];
	assign smooth_step_o    = smooth_bus.step;

endmodule

// *** ftc_config_regs_sva.sv ***
`timescale 1ns/1ps
module ftc_config_regs_sva #(
	parameter int SPIN_CYCLES = 8
) (
	input wire logic        clk_i,              // Clock
	input wire logic        rst_i,              // Reset
	input wire logic        cyc_i,              // Cycle
	input wire logic        stb_i,              // Strobe
	input wire logic        we_i,               // Write
	input wire logic [8:0]  adr_i,              // Address
	input wire logic [3:0]  sel_i,              // Selects
	input wire logic [31:0] dat_i,              // Write data
	input wire logic [31:0] dat_o,              // Read data
	input wire logic        ack_o,              // Ack
	input wire logic [2:0]  smooth_tick_i,      // Ticks
	input wire logic [2:0]  smooth_step_o,      // Steps
	input wire logic        thermal_overtemp_i, // Thermal
	input wire logic        manual_mode_i,      // Manual
	input wire logic [23:0] fan_duty_i,         // Duty in
	input wire logic [23:0] fan_duty_o,         // Duty out
	input wire logic        core_voltage_low_i, // Core low
	input wire logic        hot_monitor_en_o,   // Hot monitor
	input wire logic        monitoring_go_o,    // Go
	input wire logic        alert_o,            // Alert
	input wire logic        irq_o               // Interrupt
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ****************************************
	// Bus handshake
	// ****************************************
	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	a_ack_answer: assert property (s_req |=> ack_o) else $error("no ack after request");
	a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack longer than a cycle");
	a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
	a_read_upper: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("upper data set");

	// ****************************************
	// Fan, smoothing, reset and hot-monitor behaviour
	// ****************************************
	a_thermal_overtemp_signal_force: assert property (
		thermal_overtemp_i && !manual_mode_i |=> fan_duty_o == 24'hffffff)
		else $error("thermal event not forcing fans");
	// A step can only follow a base tick of the same channel
	a_step_one: assert property (smooth_step_o[0] |-> $past(smooth_tick_i[0]))
		else $error("step 0 without tick");
	a_step_two: assert property (smooth_step_o[1] |-> $past(smooth_tick_i[1]))
		else $error("step 1 without tick");
	a_step_three: assert property (smooth_step_o[2] |-> $past(smooth_tick_i[2]))
		else $error("step 2 without tick");
	a_reset_vals: assert property ($past(rst_i) |-> hot_monitor_en_o && !irq_o && !alert_o
		&& !monitoring_go_o && fan_duty_o == 24'h0) else $error("bad value after reset");
	a_hot_off: assert property ($fell(hot_monitor_en_o) |-> $past(core_voltage_low_i, 2))
		else $error("hot monitor off without core low");
endmodule
bind ftc_config_regs ftc_config_regs_sva #(.SPIN_CYCLES(SPIN_CYCLES)) chk (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
	.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .smooth_tick_i(smooth_tick_i),
	.smooth_step_o(smooth_step_o), .thermal_overtemp_i(thermal_overtemp_i),
	.manual_mode_i(manual_mode_i), .fan_duty_i(fan_duty_i), .fan_duty_o(fan_duty_o),
	.core_voltage_low_i(core_voltage_low_i), .hot_monitor_en_o(hot_monitor_en_o),
	.monitoring_go_o(monitoring_go_o), .alert_o(alert_o), .irq_o(irq_o));

// *** ftc_host_model.sv ***
`timescale 1ns/1ps
module ftc_host_model (
	input  wire logic        clk_i, // Clock
	output logic             cyc_o, // Cycle
	output logic             stb_o, // Strobe
	output logic             we_o,  // Write
	output logic      [8:0]  adr_o, // Address
	output logic      [3:0]  sel_o, // Selects
	output logic      [31:0] dat_o, // Write data
	input  wire logic [31:0] dat_i, // Read data
	input  wire logic        ack_i  // Ack
);
	initial
	begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o  = 1'b0;
		adr_o = 9'h000;
		sel_o = 4'h0;
		dat_o = 32'h0;
	end

	// ****************************************
	// Classic cycle, held until ack is seen
	// ****************************************
	task automatic xfer(input logic w, input logic [6:0] idx, input logic [7:0] v,
		output logic [7:0] r);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o  <= w;
		adr_o <= {idx, 2'b00};
		sel_o <= 4'h1;
		dat_o <= {24'h0, v};
		do @(posedge clk_i); while (ack_i !== 1'b1);
		r = dat_i[7:0];
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		dat_o <= ~{24'h0, v}; // Released data never keeps its last value
	endtask
	// Reserved smoothing bits are never written
	task automatic wr(input logic [6:0] idx, input logic [7:0] v);
		logic [7:0] r;
		xfer(1'b1, idx, (idx == ftc_pkg::IDX_SMOOTH_CFG) ? (v & ftc_pkg::SMOOTH_CFG_WMASK) : v, r);
	endtask
	task automatic rd(input logic [6:0] idx, output logic [7:0] r);
		xfer(1'b0, idx, 8'h00, r);
	endtask
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
	$display("[ERR] %s expected %h seen %h", nm, e, g); end end
module testbench;
	logic        clk_i;
	logic        rst_i;
	logic        cyc, stb, we, ack, thermal_overtemp_signal, manual, core_low, hot_en, go, alert, irq;
	logic [8:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat;
	logic [2:0]  tick, step;
	logic [23:0] duty, duty_o;
	logic [7:0]  rv;
	int          n_errors = 0;
	int          compares = 0;
	int          cycles = 0;
	int          cnt[3] = '{0, 0, 0};
	int          base[3];

	ftc_host_model host (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
		.sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));
	// Short spin-up keeps the run brief
	ftc_config_regs #(.SPIN_CYCLES(8)) DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat),
		.ack_o(ack), .smooth_tick_i(tick), .smooth_step_o(step), .thermal_overtemp_i(thermal_overtemp_signal),
		.manual_mode_i(manual), .fan_duty_i(duty), .fan_duty_o(duty_o),
		.core_voltage_low_i(core_low), .hot_monitor_en_o(hot_en), .monitoring_go_o(go),
		.alert_o(alert), .irq_o(irq));

	// ****************************************
	// Clock, step counters, timeout
	// ****************************************
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		for (int k = 0; k < 3; k++)
			if (step[k] === 1'b1) cnt[k]++;
		cycles++;
		if (cycles == 10000)
		begin
			n_errors++;
			test_done();
		end
	end

	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic wait_n(int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic rdchk(string nm, logic [6:0] idx, logic [7:0] e);
		host.rd(idx, rv);
		`CHK(nm, e, rv)
	endtask
	// Ticks on all channels two cycles apart; base snapshot for step counts
	task automatic ticks(int n);
		base = cnt;
		repeat (n)
		begin
			@(posedge clk_i);
			tick <= 3'h7;
			@(posedge clk_i);
			tick <= 3'h0;
		end
		wait_n(3);
	endtask

	// ****************************************
	// Test sequence
	// ****************************************
	initial
	begin
		rst_i = 1'b1;
		tick = 3'h0;
		thermal_overtemp_signal = 1'b0;
		manual = 1'b0;
		duty = 24'h123456;
		core_low = 1'b0;
		wait_n(6);
		rst_i <= 1'b0;
		for (int i = 'h72; i < 'h80; i++)
			rdchk("default", (i == 'h72) ? 7'h10 : 7'(i), (i == 'h7b) ? 8'h55 : (i == 'h7c) ? 8'h01 : 8'h00);
		rdchk("cfg one default", 7'h40, 8'h04);
		$display("reset test done");
		host.wr(7'h10, 8'h80);
		ticks(1392);
		for (int k = 0; k < 3; k++) `CHK("stretch steps", 1000, cnt[k] - base[k])
		host.wr(7'h10, 8'h05);
		ticks(8);
		`CHK("slow remote one", 2, cnt[0] - base[0])
		`CHK("local unslowed", 8, cnt[1] - base[1])
		`CHK("slow remote two", 2, cnt[2] - base[2])
		host.wr(7'h10, 8'h02);
		ticks(8);
		`CHK("slow local", 2, cnt[1] - base[1])
		$display("smoothing test done");
		for (int i = 'h73; i < 'h80; i++) host.wr(7'(i), 8'h5a ^ 8'(i));
		for (int i = 'h73; i < 'h80; i++)
			rdchk("readback", 7'(i), (i == 'h79 || i >= 'h7e) ? 8'h00 : 8'h5a ^ 8'(i));
		host.wr(7'h10, 8'hcf);
		rdchk("smooth cfg", 7'h10, 8'hcf);
		host.wr(7'h20, 8'h77);
		rdchk("unmapped", 7'h20, 8'h00);
		$display("register test done");
		host.wr(7'h10, 8'h00);
		thermal_overtemp_signal <= 1'b1;
		wait_n(3);
		`CHK("thermal_overtemp_signal auto", 24'hffffff, duty_o)
		rdchk("timer status", 7'h79, 8'h01);
		manual <= 1'b1;
		wait_n(3);
		`CHK("thermal_overtemp_signal manual off", 24'h123456, duty_o)
		host.wr(7'h10, 8'h08);
		wait_n(3);
		`CHK("thermal_overtemp_signal manual on", 24'hffffff, duty_o)
		thermal_overtemp_signal <= 1'b0;
		manual <= 1'b0;
		$display("thermal test done");
		host.wr(7'h74, 8'h00);
		host.wr(7'h78, 8'h01);
		host.wr(7'h10, 8'h40);
		core_low <= 1'b1;
		wait_n(5);
		`CHK("hot monitor off", 1'b0, hot_en)
		`CHK("irq core low", 1'b1, irq)
		`CHK("alert core low", 1'b1, alert)
		rdchk("int status", 7'h41, 8'h02);
		host.wr(7'h74, 8'h02);
		wait_n(3);
		`CHK("irq masked", 1'b0, irq)
		host.wr(7'h74, 8'h00);
		core_low <= 1'b0;
		wait_n(3);
		`CHK("spin duty", 24'hffffff, duty_o)
		wait_n(12);
		`CHK("duty resumed", 24'h123456, duty_o)
		`CHK("hot monitor on", 1'b1, hot_en)
		host.wr(7'h41, 8'h02);
		wait_n(3);
		`CHK("irq cleared", 1'b0, irq)
		$display("core low test done");
		host.wr(7'h40, 8'h03);
		wait_n(2);
		`CHK("go set", 1'b1, go)
		host.wr(7'h73, 8'h11);
		rdchk("locked cfg two", 7'h73, 8'h29);
		host.wr(7'h7a, 8'h22);
		rdchk("timer limit", 7'h7a, 8'h22);
		host.wr(7'h40, 8'h00);
		wait_n(2);
		`CHK("go cleared", 1'b0, go)
		$display("lock test done");
		test_done();
	end
endmodule
